// >>> verilog/fpnh_regs.svh
`ifndef FPNH_REGS_SVH
`define FPNH_REGS_SVH
// system register byte addresses
`define FPNH_CTXCTL_ADDR   32'he000ef34
`define FPNH_CTXADR_ADDR   32'he000ef38
`define FPNH_DFLTSC_ADDR   32'he000ef3c
`define FPNH_FEAT0_ADDR    32'he000ef40
`define FPNH_FEAT1_ADDR    32'he000ef44
`define FPNH_CPACC_ADDR    32'he000ed88
`define FPNH_STATUS_ADDR   32'he000ef48
// reset values and writable masks
`define FPNH_CTXCTL_RST    32'hc0000000
`define FPNH_CTXCTL_WMASK  32'hc0000001
`define FPNH_CTXADR_RST    32'h00000000
`define FPNH_CTXADR_WMASK  32'hfffffff8
`define FPNH_DFLTSC_RST    32'h00000000
`define FPNH_DFLTSC_WMASK  32'h07c00000
`define FPNH_FEAT0_VAL     32'h10110021
`define FPNH_FEAT1_VAL     32'h11000011
`define FPNH_CPACC_RST     32'h00000000
`define FPNH_CPACC_WMASK   32'h00f00000
`define FPNH_STATUS_RST    32'h00000000
`define FPNH_STATUS_WMASK  32'hf7c0009f
// field positions
`define FPNH_INVALID_BIT   0
`define FPNH_DIVZERO_BIT   1
`define FPNH_OVERFLOW_BIT  2
`define FPNH_UNDERFLOW_BIT 3
`define FPNH_INEXACT_BIT   4
`define FPNH_DENORM_BIT    7
`define FPNH_FLUSH_BIT     24
`define FPNH_DEFNAN_BIT    25
`define FPNH_NZCV_LSB      28
`define FPNH_LSPACT_BIT    0
`define FPNH_LSPEN_BIT     30
`define FPNH_CPA_LSB       20
`define FPNH_CPB_LSB       22
`define FPNH_QUIET_BIT     22
// constant values
`define FPNH_DEFAULT_NAN   32'h7fc00000
`define FPNH_NZCV_UNORD    4'h3
`define FPNH_NZCV_EQ       4'h6
`define FPNH_NZCV_LT       4'h8
`define FPNH_NZCV_GT       4'h2
`endif

// >>> verilog/fpnh_pkg.sv
package fpnh_pkg;
  typedef enum logic [3:0] {
    FPNH_OP_ARITH    = 4'b0000,
    FPNH_OP_XFER     = 4'b0001,
    FPNH_OP_ABS      = 4'b0010,
    FPNH_OP_NEG      = 4'b0011,
    FPNH_OP_MOVE     = 4'b0100,
    FPNH_OP_CMP_Q    = 4'b0101,
    FPNH_OP_CMP_S    = 4'b0110,
    FPNH_OP_FLAGS    = 4'b0111,
    FPNH_OP_WR_STAT  = 4'b1000,
    FPNH_OP_RD_STAT  = 4'b1001
  } fpnh_op_t;

  // raw outcome of the arithmetic core for the current op
  typedef struct packed {
    logic [31:0] value;
    logic        tiny;
    logic        inexact;
    logic        overflow;
    logic        divzero;
    logic        invalid;
  } fpnh_raw_t;

  typedef struct packed {
    logic is_nan;
    logic is_snan;
    logic is_sub;
    logic is_zero;
  } fpnh_class_t;
endpackage : fpnh_pkg

// >>> verilog/fpnh_classify.sv
`timescale 1ns/1ps
module fpnh_classify
  import fpnh_pkg::*;
(
  input  wire logic [31:0] value,
  output fpnh_class_t      cls
);
  logic exp_ones;
  logic exp_zero;
  logic frac_nz;

  assign exp_ones     = &value[30:23];
  assign exp_zero     = ~|value[30:23];
  assign frac_nz      = |value[22:0];
  // all-ones exponent, nonzero fraction; top fraction bit low means signalling
  assign cls.is_nan   = exp_ones & frac_nz;
  assign cls.is_snan  = exp_ones & frac_nz & ~value[22];
  assign cls.is_sub   = exp_zero & frac_nz;
  assign cls.is_zero  = exp_zero & ~frac_nz;
endmodule : fpnh_classify

// >>> verilog/fpnh_nan_pick.sv
`timescale 1ns/1ps
`include "fpnh_regs.svh"
module fpnh_nan_pick
  import fpnh_pkg::*;
(
  input  wire logic [31:0] op_a,
  input  wire logic [31:0] op_b,
  input  fpnh_class_t      cls_a,
  input  fpnh_class_t      cls_b,
  input  wire logic        default_nan_enable,
  output logic [31:0]      nan_out,
  output logic             any_nan,
  output logic             any_snan
);
  assign any_nan  = cls_a.is_nan | cls_b.is_nan;
  assign any_snan = cls_a.is_snan | cls_b.is_snan;

  always_comb begin
    if (default_nan_enable) begin
      nan_out = `FPNH_DEFAULT_NAN;
    end else if (cls_a.is_snan) begin
      nan_out = op_a | (32'h1 << `FPNH_QUIET_BIT);
    end else if (cls_b.is_snan) begin
      nan_out = op_b | (32'h1 << `FPNH_QUIET_BIT);
    end else if (cls_a.is_nan) begin
      nan_out = op_a;
    end else begin
      nan_out = op_b;
    end
  end
endmodule : fpnh_nan_pick

// >>> verilog/fpnh_unit.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "fpnh_regs.svh"
module fpnh_unit
  import fpnh_pkg::*;
#(
  parameter int ADDR_W = 32
)
(
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [2:0]        pprot,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              op_valid,
  input  fpnh_op_t               op_kind,
  input  wire logic [31:0]       op_a,
  input  wire logic [31:0]       op_b,
  input  fpnh_raw_t              raw,
  input  wire logic              exc_entry,
  input  wire logic              ctx_active,
  input  wire logic [31:0]       frame_addr,
  output logic                   res_valid,
  output logic [31:0]            res_data,
  output logic [3:0]             core_flags,
  output logic                   fp_fault,
  output logic                   lazy_reserve,
  output logic                   flush_zero_mode,
  output logic                   pin_inexact_out,
  output logic                   pin_underflow_out,
  output logic                   pin_overflow_out,
  output logic                   pin_divzero_out,
  output logic                   pin_denormal_out,
  output logic                   pin_invalid_out
);
  if (ADDR_W != 32) begin : g_addr_w_chk
    $error("fpnh_unit: ADDR_W must be 32");
  end

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [31:0] r);
    addr_is = (a == r);
  endfunction : addr_is

  logic [31:0] status_q;
  logic [31:0] cp_access_q;
  logic [31:0] ctx_ctrl_q;
  logic [31:0] ctx_addr_q;
  logic [31:0] dflt_stat_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        res_valid_q;
  logic [31:0] res_data_q;
  logic [3:0]  core_flags_q;
  logic        fp_fault_q;
  logic        lazy_q;

  // operand classification
  logic [31:0] opnd [2];
  fpnh_class_t cls  [2];
  assign opnd[0] = op_a;
  assign opnd[1] = op_b;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cls
      fpnh_classify u_cls (
        .value (opnd[gi]),
        .cls   (cls[gi])
      );
    end
  endgenerate

  logic        flush_zero_enable;
  logic        default_nan_enable;
  logic [31:0] nan_res;
  logic        any_nan;
  logic        any_snan;

  assign flush_zero_enable  = status_q[`FPNH_FLUSH_BIT];
  assign default_nan_enable = status_q[`FPNH_DEFNAN_BIT];

  fpnh_nan_pick u_pick (
    .op_a               (op_a),
    .op_b               (op_b),
    .cls_a              (cls[0]),
    .cls_b              (cls[1]),
    .default_nan_enable (default_nan_enable),
    .nan_out            (nan_res),
    .any_nan            (any_nan),
    .any_snan           (any_snan)
  );

  // access gate: both coprocessor fields must be nonzero
  logic fp_enabled;
  logic op_go;
  assign fp_enabled = |cp_access_q[`FPNH_CPA_LSB +: 2] & |cp_access_q[`FPNH_CPB_LSB +: 2];
  assign op_go      = op_valid & fp_enabled;

  // flushed operands for compare
  logic [31:0] cmp_a;
  logic [31:0] cmp_b;
  logic        in_flush;
  assign cmp_a    = (flush_zero_enable & cls[0].is_sub) ? {op_a[31], 31'h0} : op_a;
  assign cmp_b    = (flush_zero_enable & cls[1].is_sub) ? {op_b[31], 31'h0} : op_b;
  assign in_flush = flush_zero_enable & (cls[0].is_sub | cls[1].is_sub);

  // ordered compare result
  logic [3:0] ord_nzcv;
  logic       both_zero;
  logic       a_lt_b;
  assign both_zero = (cmp_a[30:0] == 31'h0) & (cmp_b[30:0] == 31'h0);
  always_comb begin
    if (cmp_a[31] != cmp_b[31]) begin
      a_lt_b = cmp_a[31];
    end else if (cmp_a[31]) begin
      a_lt_b = cmp_a[30:0] > cmp_b[30:0];
    end else begin
      a_lt_b = cmp_a[30:0] < cmp_b[30:0];
    end
    if (both_zero || cmp_a == cmp_b) begin
      ord_nzcv = `FPNH_NZCV_EQ;
    end else if (a_lt_b) begin
      ord_nzcv = `FPNH_NZCV_LT;
    end else begin
      ord_nzcv = `FPNH_NZCV_GT;
    end
  end

  // arithmetic result and new exception flags
  fpnh_class_t raw_cls;
  logic [31:0] arith_res;
  logic [7:0]  arith_flags;
  fpnh_classify u_raw_cls (
    .value (raw.value),
    .cls   (raw_cls)
  );
  always_comb begin
    arith_flags                   = 8'h00;
    arith_flags[`FPNH_DENORM_BIT] = in_flush;
    if (any_nan) begin
      arith_res                        = nan_res;
      arith_flags[`FPNH_INVALID_BIT]   = any_snan;
    end else if (raw_cls.is_nan) begin
      arith_res = default_nan_enable ? `FPNH_DEFAULT_NAN : raw.value;
      arith_flags[`FPNH_INVALID_BIT]   = raw.invalid;
    end else if (raw.tiny && flush_zero_enable) begin
      arith_res                        = {raw.value[31], 31'h0};
      arith_flags[`FPNH_UNDERFLOW_BIT] = 1'b1;
      arith_flags[`FPNH_DIVZERO_BIT]   = raw.divzero;
    end else begin
      arith_res                        = raw.value;
      arith_flags[`FPNH_UNDERFLOW_BIT] = raw.tiny & raw.inexact;
      arith_flags[`FPNH_INEXACT_BIT]   = raw.inexact;
      arith_flags[`FPNH_OVERFLOW_BIT]  = raw.overflow;
      arith_flags[`FPNH_DIVZERO_BIT]   = raw.divzero;
      arith_flags[`FPNH_INVALID_BIT]   = raw.invalid;
    end
  end

  // per-op new flags
  logic [7:0] new_flags;
  always_comb begin
    new_flags = 8'h00;
    if (op_go) begin
      unique case (op_kind)
        FPNH_OP_ARITH: new_flags = arith_flags;
        FPNH_OP_CMP_Q: new_flags[`FPNH_INVALID_BIT] = any_snan;
        FPNH_OP_CMP_S: new_flags[`FPNH_INVALID_BIT] = any_nan;
        default:       new_flags = 8'h00;
      endcase
      if (op_kind == FPNH_OP_CMP_Q || op_kind == FPNH_OP_CMP_S) begin
        new_flags[`FPNH_DENORM_BIT] = in_flush;
      end
    end
  end

  // apb handshake: answer in the second access cycle
  logic apb_access;
  logic apb_commit;
  logic apb_priv;
  logic addr_hit;
  assign apb_access = psel & penable & ~pready_q;
  assign apb_commit = psel & penable & pready_q;
  assign apb_priv   = pprot[0];
  assign addr_hit   = addr_is(paddr, `FPNH_CTXCTL_ADDR) | addr_is(paddr, `FPNH_CTXADR_ADDR)
                    | addr_is(paddr, `FPNH_DFLTSC_ADDR) | addr_is(paddr, `FPNH_FEAT0_ADDR)
                    | addr_is(paddr, `FPNH_FEAT1_ADDR) | addr_is(paddr, `FPNH_CPACC_ADDR)
                    | addr_is(paddr, `FPNH_STATUS_ADDR);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (addr_is(paddr, `FPNH_CTXCTL_ADDR)) rd_mux = ctx_ctrl_q;
    if (addr_is(paddr, `FPNH_CTXADR_ADDR)) rd_mux = ctx_addr_q;
    if (addr_is(paddr, `FPNH_DFLTSC_ADDR)) rd_mux = dflt_stat_q;
    if (addr_is(paddr, `FPNH_FEAT0_ADDR))  rd_mux = `FPNH_FEAT0_VAL;
    if (addr_is(paddr, `FPNH_FEAT1_ADDR))  rd_mux = `FPNH_FEAT1_VAL;
    if (addr_is(paddr, `FPNH_CPACC_ADDR))  rd_mux = cp_access_q;
    if (addr_is(paddr, `FPNH_STATUS_ADDR)) rd_mux = status_q;
  end

  logic apb_err;
  logic apb_wr_ok;
  assign apb_err   = ~addr_hit | ~apb_priv;
  assign apb_wr_ok = apb_commit & pwrite & ~pslverr_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else if (ce) begin
      pready_q  <= apb_access;
      pslverr_q <= apb_access & apb_err;
      prdata_q  <= (apb_access & ~pwrite & ~apb_err) ? rd_mux : 32'h0;
    end
  end

  // coprocessor access control
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cp_access_q <= `FPNH_CPACC_RST;
    end else if (ce && apb_wr_ok && addr_is(paddr, `FPNH_CPACC_ADDR)) begin
      cp_access_q <= pwdata & `FPNH_CPACC_WMASK;
    end
  end

  // default status control
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dflt_stat_q <= `FPNH_DFLTSC_RST;
    end else if (ce && apb_wr_ok && addr_is(paddr, `FPNH_DFLTSC_ADDR)) begin
      dflt_stat_q <= pwdata & `FPNH_DFLTSC_WMASK;
    end
  end

  // lazy context: reserve frame, record address, save nothing
  logic lazy_hit;
  assign lazy_hit = exc_entry & ctx_active & ctx_ctrl_q[`FPNH_LSPEN_BIT];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctx_ctrl_q <= `FPNH_CTXCTL_RST;
    end else if (ce) begin
      if (apb_wr_ok && addr_is(paddr, `FPNH_CTXCTL_ADDR)) begin
        ctx_ctrl_q <= pwdata & `FPNH_CTXCTL_WMASK;
      end
      if (op_go) begin
        ctx_ctrl_q[`FPNH_LSPACT_BIT] <= 1'b0;
      end
      if (lazy_hit) begin
        ctx_ctrl_q[`FPNH_LSPACT_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctx_addr_q <= `FPNH_CTXADR_RST;
    end else if (ce) begin
      if (lazy_hit) begin
        ctx_addr_q <= frame_addr & `FPNH_CTXADR_WMASK;
      end else if (apb_wr_ok && addr_is(paddr, `FPNH_CTXADR_ADDR)) begin
        ctx_addr_q <= pwdata & `FPNH_CTXADR_WMASK;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lazy_q <= 1'b0;
    end else if (ce) begin
      lazy_q <= lazy_hit;
    end
  end

  // fp status register: sticky flags, trap enables forced to zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_q <= `FPNH_STATUS_RST;
    end else if (ce && op_go) begin
      if (op_kind == FPNH_OP_WR_STAT) begin
        status_q <= op_a & `FPNH_STATUS_WMASK;
      end else begin
        status_q[7:0] <= status_q[7:0] | new_flags;
        if (op_kind == FPNH_OP_CMP_Q || op_kind == FPNH_OP_CMP_S) begin
          status_q[`FPNH_NZCV_LSB +: 4] <= any_nan ? `FPNH_NZCV_UNORD : ord_nzcv;
        end
      end
    end
  end

  // result path
  logic [31:0] res_d;
  always_comb begin
    unique case (op_kind)
      FPNH_OP_ARITH:   res_d = arith_res;
      FPNH_OP_XFER:    res_d = op_a;
      FPNH_OP_ABS:     res_d = {1'b0, op_a[30:0]};
      FPNH_OP_NEG:     res_d = {~op_a[31], op_a[30:0]};
      FPNH_OP_MOVE:    res_d = op_a;
      FPNH_OP_RD_STAT: res_d = status_q;
      default:         res_d = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      res_valid_q <= 1'b0;
      res_data_q  <= 32'h0;
      fp_fault_q  <= 1'b0;
    end else if (ce) begin
      res_valid_q <= op_go;
      fp_fault_q  <= op_valid & ~fp_enabled;
      if (op_go) begin
        res_data_q <= res_d;
      end
    end
  end

  // flag transfer to core status
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      core_flags_q <= 4'h0;
    end else if (ce && op_go && op_kind == FPNH_OP_FLAGS) begin
      core_flags_q <= status_q[`FPNH_NZCV_LSB +: 4];
    end
  end

  // outputs
  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign res_valid         = res_valid_q;
  assign res_data          = res_data_q;
  assign core_flags        = core_flags_q;
  assign fp_fault          = fp_fault_q;
  assign lazy_reserve      = lazy_q;
  assign flush_zero_mode   = status_q[`FPNH_FLUSH_BIT];
  assign pin_inexact_out   = status_q[`FPNH_INEXACT_BIT];
  assign pin_underflow_out = status_q[`FPNH_UNDERFLOW_BIT];
  assign pin_overflow_out  = status_q[`FPNH_OVERFLOW_BIT];
  assign pin_divzero_out   = status_q[`FPNH_DIVZERO_BIT];
  assign pin_denormal_out  = status_q[`FPNH_DENORM_BIT];
  assign pin_invalid_out   = status_q[`FPNH_INVALID_BIT];
endmodule : fpnh_unit

// >>> tb/fpnh_unit_properties.sv
`timescale 1ns/1ps
module fpnh_unit_properties
  import fpnh_pkg::*;
#(
  parameter int ADDR_W = 32
)
(
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [2:0]  pprot,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        op_valid,
  input fpnh_op_t         op_kind,
  input wire logic [31:0] op_a,
  input wire logic        res_valid,
  input wire logic [31:0] res_data,
  input wire logic        fp_fault,
  input wire logic        lazy_reserve,
  input wire logic        exc_entry,
  input wire logic        ctx_active,
  input wire logic        pin_invalid_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  logic [31:0] op_a_q;
  always_ff @(posedge ref_clk) begin
    op_a_q <= op_a;
  end

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready;
  endsequence

  AST_PREADY_WAIT:
    assert property (s_setup ##1 s_wait |=> pready) else $error("pready late");
  AST_RDATA_IDLE:
    assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
  AST_PRIV_ERR:
    assert property (psel && penable && pready && !pprot[0] |-> pslverr) else $error("no error");
  AST_FAULT_CAUSE:
    assert property (fp_fault |-> $past(op_valid) && !res_valid) else $error("stray fault");
  AST_XFER_COPY:
    assert property (op_valid && op_kind inside {FPNH_OP_XFER, FPNH_OP_MOVE}
      |=> fp_fault || (res_valid && res_data == op_a_q)) else $error("copy changed");
  AST_NEG_SIGN:
    assert property (op_valid && op_kind == FPNH_OP_NEG
      |=> fp_fault || res_data == {~op_a_q[31], op_a_q[30:0]}) else $error("negate");
  AST_NO_IOC_COPY:
    assert property (op_valid && !pin_invalid_out && op_kind inside {FPNH_OP_XFER,
      FPNH_OP_ABS, FPNH_OP_NEG, FPNH_OP_MOVE} |=> !pin_invalid_out) else $error("copy ioc");
  AST_SIGCMP_IOC:
    assert property (op_valid && op_kind == FPNH_OP_CMP_S && op_a[30:23] == 8'hff
      && op_a[22:0] != 23'h0 |=> fp_fault || pin_invalid_out) else $error("cmp ioc");
  AST_FLAG_HOLD:
    assert property (pin_invalid_out && !(op_valid && op_kind == FPNH_OP_WR_STAT)
      |=> pin_invalid_out) else $error("flag lost");
  AST_LAZY_CAUSE:
    assert property (lazy_reserve |-> $past(exc_entry) && $past(ctx_active))
      else $error("stray lazy");
endmodule : fpnh_unit_properties

bind fpnh_unit fpnh_unit_properties #(.ADDR_W(ADDR_W)) fpnh_unit_properties_i (
  .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pprot(pprot),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_valid(op_valid),
  .op_kind(op_kind), .op_a(op_a), .res_valid(res_valid), .res_data(res_data),
  .fp_fault(fp_fault), .lazy_reserve(lazy_reserve), .exc_entry(exc_entry),
  .ctx_active(ctx_active), .pin_invalid_out(pin_invalid_out));

// >>> tb/fpnh_unit_tb_top.sv
`timescale 1ns/1ps
`include "fpnh_regs.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module fpnh_unit_tb_top
  import fpnh_pkg::*;
;
  logic        ref_clk, srst, ce, psel, penable, pwrite, op_valid, exc_entry, ctx_active;
  logic [31:0] paddr, pwdata, op_a, op_b, frame_addr, prdata, res_data, rd;
  logic [2:0]  pprot;
  fpnh_op_t    op_kind;
  fpnh_raw_t   raw;
  logic        pready, pslverr, res_valid, fp_fault, lazy_reserve, flush_zero_mode, err;
  logic [3:0]  core_flags;
  logic [5:0]  pins;
  int          miscompares, checks_done, cycles;
  fpnh_op_t    kt[4] = '{FPNH_OP_XFER, FPNH_OP_MOVE, FPNH_OP_NEG, FPNH_OP_ABS};
  logic [31:0] et[4] = '{32'hff800001, 32'hff800001, 32'h7f800001, 32'h7f800001};

  fpnh_unit fpnh_unit_i (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .op_valid(op_valid), .op_kind(op_kind),
    .op_a(op_a), .op_b(op_b), .raw(raw), .exc_entry(exc_entry), .ctx_active(ctx_active),
    .frame_addr(frame_addr), .res_valid(res_valid), .res_data(res_data),
    .core_flags(core_flags), .fp_fault(fp_fault), .lazy_reserve(lazy_reserve),
    .flush_zero_mode(flush_zero_mode), .pin_inexact_out(pins[4]),
    .pin_underflow_out(pins[3]), .pin_overflow_out(pins[2]), .pin_divzero_out(pins[1]),
    .pin_denormal_out(pins[5]), .pin_invalid_out(pins[0]));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic test_done();
    if (miscompares == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [2:0] pr);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pprot   <= pr;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [31:0] a, input logic [31:0] e,
                      input logic [2:0] pr = 3'h1, input logic ee = 1'b0);
    apb(1'b0, a, 32'h0, pr);
    `CHK(rd, e)
    `CHK(err, ee)
  endtask : rchk

  task automatic op(input fpnh_op_t k, input logic [31:0] a, input logic [31:0] b = 32'h0,
                    input fpnh_raw_t r = '0);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_kind  <= k;
    op_a     <= a;
    op_b     <= b;
    raw      <= r;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    #1;
  endtask : op

  initial begin
    {psel, penable, pwrite, op_valid, exc_entry, ctx_active} = '0;
    {paddr, pwdata, op_a, op_b, frame_addr} = '0;
    {miscompares, checks_done, cycles} = '0;
    pprot = 3'h1;
    op_kind = FPNH_OP_ARITH;
    raw = '0;
    ce = 1'b1;
    srst = 1'b1;
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    rchk(`FPNH_CTXCTL_ADDR, 32'hc0000000);
    rchk(`FPNH_DFLTSC_ADDR, 32'h00000000);
    rchk(`FPNH_FEAT0_ADDR, 32'h10110021);
    rchk(`FPNH_FEAT1_ADDR, 32'h11000011);
    rchk(32'he000ef50, 32'h0, 3'h1, 1'b1);
    rchk(`FPNH_CPACC_ADDR, 32'h0, 3'h0, 1'b1);
    apb(1'b1, `FPNH_FEAT0_ADDR, 32'h0, 3'h1);
    `CHK(err, 1'b0)
    rchk(`FPNH_FEAT0_ADDR, 32'h10110021);
    op(FPNH_OP_XFER, 32'h1);
    `CHK(fp_fault, 1'b1)
    `CHK(res_valid, 1'b0)
    apb(1'b0, `FPNH_CPACC_ADDR, 32'h0, 3'h1);
    apb(1'b1, `FPNH_CPACC_ADDR, rd | (32'hf << 20), 3'h1);
    rchk(`FPNH_CPACC_ADDR, 32'h00f00000);
    for (int i = 0; i < 4; i++) begin
      op(kt[i], 32'hff800001);
      `CHK(res_data, et[i])
      `CHK(pins[0], 1'b0)
      `CHK(res_valid, 1'b1)
    end
    op(FPNH_OP_ARITH, 32'h3f800000, 32'h7fc00055);
    `CHK(res_data, 32'h7fc00055)
    op(FPNH_OP_CMP_Q, 32'h3f800000, 32'h3f800000);
    op(FPNH_OP_FLAGS, 32'h0);
    `CHK(core_flags, 4'h6)
    op(FPNH_OP_CMP_Q, 32'h3f800000, 32'h40000000);
    op(FPNH_OP_FLAGS, 32'h0);
    `CHK(core_flags, `FPNH_NZCV_LT)
    op(FPNH_OP_CMP_Q, 32'h7fc00001, 32'h3f800000);
    op(FPNH_OP_FLAGS, 32'h0);
    `CHK(core_flags, 4'h3)
    `CHK(pins[0], 1'b0)
    op(FPNH_OP_CMP_S, 32'h7fc00001, 32'h0);
    `CHK(pins[0], 1'b1)
    op(FPNH_OP_XFER, 32'h0);
    `CHK(pins[0], 1'b1)
    op(FPNH_OP_WR_STAT, 32'h0);
    `CHK(pins[0], 1'b0)
    op(FPNH_OP_ARITH, 32'h7f800001, 32'h7fc00002);
    `CHK(res_data, 32'h7fc00001)
    `CHK(pins[0], 1'b1)
    op(FPNH_OP_WR_STAT, 32'h02009f00);
    rchk(`FPNH_STATUS_ADDR, 32'h02000000);
    ce <= 1'b0;
    op(FPNH_OP_ARITH, 32'h7f800001, 32'h0);
    `CHK(res_valid, 1'b0)
    `CHK(pins[0], 1'b0)
    ce <= 1'b1;
    op(FPNH_OP_RD_STAT, 32'h0);
    `CHK(res_data, 32'h02000000)
    op(FPNH_OP_ARITH, 32'h3f800000, 32'h7fc00055);
    `CHK(res_data, 32'h7fc00000)
    `CHK(pins[0], 1'b0)
    op(FPNH_OP_ARITH, 32'h7f800001, 32'h0);
    `CHK(res_data, 32'h7fc00000)
    `CHK(pins[0], 1'b1)
    op(FPNH_OP_WR_STAT, 32'h01000000);
    `CHK(flush_zero_mode, 1'b1)
    op(FPNH_OP_ARITH, 32'h00000001, 32'h3f800000, {32'h00000010, 5'b10000});
    `CHK(res_data, 32'h0)
    `CHK(pins[3], 1'b1)
    `CHK(pins[5], 1'b1)
    op(FPNH_OP_WR_STAT, 32'h0);
    op(FPNH_OP_ARITH, 32'h3f800000, 32'h3f800000, {32'h00000010, 5'b10000});
    `CHK(res_data, 32'h00000010)
    `CHK(pins[3], 1'b0)
    op(FPNH_OP_ARITH, 32'h3f800000, 32'h3f800000, {32'h3f800001, 5'b01000});
    `CHK(pins[4:3], 2'b10)
    op(FPNH_OP_ARITH, 32'h3f800000, 32'h3f800000, {32'h00000010, 5'b11000});
    `CHK(pins[3], 1'b1)
    op(FPNH_OP_ARITH, 32'h3f800000, 32'h3f800000, {32'h3f800000, 5'b00110});
    `CHK(pins[4:1], 4'hf)
    @(posedge ref_clk);
    exc_entry  <= 1'b1;
    ctx_active <= 1'b1;
    frame_addr <= 32'h20001237;
    @(posedge ref_clk);
    exc_entry <= 1'b0;
    #1;
    `CHK(lazy_reserve, 1'b1)
    rchk(`FPNH_CTXCTL_ADDR, 32'hc0000001);
    rchk(`FPNH_CTXADR_ADDR, 32'h20001230);
    op(FPNH_OP_XFER, 32'h0);
    rchk(`FPNH_CTXCTL_ADDR, 32'hc0000000);
    test_done();
  end
endmodule : fpnh_unit_tb_top
